// File: ocs_consts.svh
// constants for the operation-complete / clear-status block
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH
`define OCS_ADDR_CMD 12'h000
`define OCS_ADDR_MEAS 12'h004
`define OCS_ADDR_ESE 12'h008
`define OCS_ADDR_SRE 12'h00c
`define OCS_ADDR_ESR 12'h010
`define OCS_ADDR_STB 12'h014
`define OCS_ADDR_OUTQ 12'h018
`define OCS_ADDR_EVT 12'h01c
`define OCS_ADDR_ERRQ 12'h020
`define OCS_ADDR_IRQ_STAT 12'h024
`define OCS_ADDR_IRQ_EN 12'h028
`define OCS_ADDR_IRQ_CLR 12'h02c
`define OCS_ADDR_FLAGS 12'h030
`define OCS_CMD_OPC 3'h1
`define OCS_CMD_OPCQ 3'h2
`define OCS_CMD_WAI 3'h3
`define OCS_CMD_CLS 3'h4
`define OCS_CMD_OTHER 3'h5
`define OCS_ESR_OPC_BIT 0
`define OCS_STB_MAV_BIT 4
`define OCS_STB_ESB_BIT 5
`define OCS_STB_RQS_BIT 6
`define OCS_SETTLE_S 1
`define OCS_CLK_HZ 25000000
`define OCS_REPLY_CHAR 8'h31
`endif

// File: ocs_pkg.sv
// types for the operation-complete / clear-status block
package ocs_pkg;
  typedef enum logic [1:0] {OCS_IDLE, OCS_SETTLE, OCS_DONE} ocs_sync_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } ocs_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ocs_apb_rsp_t;
endpackage

// File: ocs_settle_timer.sv
// settling timer: runs one full period after start, then flags expiry
`timescale 1ns/100ps
`include "ocs_consts.svh"
module ocs_settle_timer #(
  parameter int unsigned CYCLES = 25000000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  output logic expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic run;
    logic exp;
  } ocs_tmr_t;
  ocs_tmr_t st_ff;
  ocs_tmr_t nxt_st;
  initial begin
    if (CYCLES < 1) $error("settle timer needs at least one cycle");
  end
  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.cnt = 32'h0;
      nxt_st.run = 1'b1;
      nxt_st.exp = 1'b0;
    end else if (st_ff.run) begin
      if (st_ff.cnt == 32'(CYCLES - 1)) begin
        nxt_st.run = 1'b0;
        nxt_st.exp = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign expired = st_ff.exp;
endmodule

// File: ocs_sync_status.sv
// operation-complete, wait and clear-status command handling with apb registers
`timescale 1ns/100ps
`include "ocs_consts.svh"
module ocs_sync_status
  import ocs_pkg::*;
#(
  parameter int unsigned NUM_MEAS = 8,
  parameter int unsigned ERRQ_DEPTH = 8,
  parameter int unsigned SETTLE_CYCLES = `OCS_SETTLE_S * `OCS_CLK_HZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ocs_pkg::ocs_apb_req_t apb_req,
  output ocs_pkg::ocs_apb_rsp_t apb_rsp,
  input wire logic [NUM_MEAS-1:0] meas_active,
  input wire logic [NUM_MEAS-1:0] meas_done,
  output logic meas_report_req,
  input wire logic err_push,
  input wire logic [7:0] err_code,
  input wire logic [7:0] evt_hw1_set,
  input wire logic [7:0] evt_hw2_set,
  input wire logic [7:0] evt_qdata_set,
  input wire logic [7:0] evt_oper_set,
  input wire logic [7:0] evt_cal_set,
  input wire logic [7:0] evt_comm_set,
  output logic exec_blocked,
  output logic srq,
  output logic irq
);
  import ocs_pkg::*;
  localparam int EW = $clog2(ERRQ_DEPTH + 1);
  localparam int PW = (ERRQ_DEPTH > 1) ? $clog2(ERRQ_DEPTH) : 1;

  typedef struct packed {
    ocs_sync_t sync;
    logic [2:0] kind;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] esr;
    logic [7:0] hw1;
    logic [7:0] hw2;
    logic [7:0] qdata;
    logic [7:0] oper;
    logic [7:0] cal;
    logic [7:0] comm;
    logic [7:0] outq;
    logic outq_full;
    logic [EW-1:0] err_cnt;
    logic [PW-1:0] err_rd;
    logic [PW-1:0] err_wr;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic holdoff;
  } ocs_state_t;

  ocs_state_t st_ff;
  ocs_state_t nxt_st;
  logic [7:0] errq_ff [ERRQ_DEPTH];
  logic tmr_start;
  logic tmr_expired;
  logic meas_all_done;
  logic sync_done;
  logic [7:0] stb;
  logic wr_acc;
  logic rd_acc;
  logic [2:0] cmd;
  logic setup_ph;
  logic held_rd;
  logic cmd_ok;
  logic cls_cmd;
  logic errq_we;
  logic rd_err;
  logic wr_err;
  logic [31:0] rd_word;

  initial begin
    if (NUM_MEAS < 1 || ERRQ_DEPTH < 2 || SETTLE_CYCLES < 1) $error("ocs_sync_status: bad parameter");
    // queue pointers wrap by overflow, so the depth must be a power of two
    if ((ERRQ_DEPTH & (ERRQ_DEPTH - 1)) != 0) $error("ocs_sync_status: queue depth not a power of two");
  end

  function automatic logic [31:0] zx8(input logic [7:0] v);
    return {24'h0, v};
  endfunction

  // true for the three commands that wait for completion
  function automatic logic is_sync_cmd(input logic [2:0] c);
    logic r;
    r = 1'b0;
    unique case (c)
      `OCS_CMD_OPC: r = 1'b1;
      `OCS_CMD_OPCQ: r = 1'b1;
      `OCS_CMD_WAI: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // registers that answer a read
  function automatic logic rd_map(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    unique case (a)
      `OCS_ADDR_MEAS: ok = 1'b1;
      `OCS_ADDR_ESE: ok = 1'b1;
      `OCS_ADDR_SRE: ok = 1'b1;
      `OCS_ADDR_ESR: ok = 1'b1;
      `OCS_ADDR_STB: ok = 1'b1;
      `OCS_ADDR_OUTQ: ok = 1'b1;
      `OCS_ADDR_EVT: ok = 1'b1;
      `OCS_ADDR_ERRQ: ok = 1'b1;
      `OCS_ADDR_IRQ_STAT: ok = 1'b1;
      `OCS_ADDR_IRQ_EN: ok = 1'b1;
      `OCS_ADDR_FLAGS: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // registers that take a write
  function automatic logic wr_map(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    unique case (a)
      `OCS_ADDR_CMD: ok = 1'b1;
      `OCS_ADDR_ESE: ok = 1'b1;
      `OCS_ADDR_SRE: ok = 1'b1;
      `OCS_ADDR_IRQ_EN: ok = 1'b1;
      `OCS_ADDR_IRQ_CLR: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // an opc query reply is still owed and the output queue is empty
  function automatic logic reply_owed(input ocs_state_t s);
    return !s.outq_full && s.sync != OCS_IDLE && s.kind == `OCS_CMD_OPCQ;
  endfunction

  ocs_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_tmr (
    .clk(clk),
    .nrst(nrst),
    .start(tmr_start),
    .expired(tmr_expired)
  );

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && st_ff.pready;
  assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite && st_ff.pready;
  assign cmd = apb_req.pwdata[2:0];
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign held_rd = apb_req.psel && apb_req.penable && !apb_req.pwrite && !st_ff.pready;
  // commands are refused while a sync command is pending; the refusal is fixed in the setup cycle
  assign cmd_ok = wr_acc && apb_req.paddr == `OCS_ADDR_CMD && st_ff.sync == OCS_IDLE && !st_ff.pslverr;
  assign cls_cmd = cmd_ok && cmd == `OCS_CMD_CLS;
  assign tmr_start = cmd_ok && is_sync_cmd(cmd);
  assign rd_err = !rd_map(apb_req.paddr);
  assign wr_err = !wr_map(apb_req.paddr) || (apb_req.paddr == `OCS_ADDR_CMD && st_ff.sync != OCS_IDLE);
  assign errq_we = err_push && !cls_cmd && st_ff.err_cnt != EW'(ERRQ_DEPTH);
  assign meas_all_done = &(meas_done | ~meas_active);
  assign meas_report_req = st_ff.sync == OCS_SETTLE;
  assign sync_done = st_ff.sync == OCS_SETTLE && tmr_expired && meas_all_done;
  assign exec_blocked = st_ff.sync != OCS_IDLE && st_ff.kind == `OCS_CMD_WAI;

  always_comb begin
    stb = 8'h0;
    stb[`OCS_STB_MAV_BIT] = st_ff.outq_full;
    stb[`OCS_STB_ESB_BIT] = |(st_ff.esr & st_ff.ese);
    stb[`OCS_STB_RQS_BIT] = |(stb & st_ff.sre & 8'hbf);
  end
  assign srq = stb[`OCS_STB_RQS_BIT];

  // read data is chosen before the access edge so that it stands when the master takes it
  always_comb begin
    rd_word = 32'h0;
    unique case (apb_req.paddr)
      `OCS_ADDR_MEAS: begin
        rd_word = {31'h0, meas_all_done};
      end
      `OCS_ADDR_ESE: begin
        rd_word = zx8(st_ff.ese);
      end
      `OCS_ADDR_SRE: begin
        rd_word = zx8(st_ff.sre);
      end
      `OCS_ADDR_ESR: begin
        rd_word = zx8(st_ff.esr);
      end
      `OCS_ADDR_STB: begin
        rd_word = zx8(stb);
      end
      `OCS_ADDR_OUTQ: begin
        rd_word = zx8(st_ff.outq);
      end
      `OCS_ADDR_EVT: begin
        rd_word = {st_ff.comm[3:0], st_ff.cal[3:0], st_ff.oper[3:0],
          st_ff.qdata[3:0], st_ff.hw2[3:0], st_ff.hw1[3:0], 8'h0};
      end
      `OCS_ADDR_ERRQ: begin
        if (st_ff.err_cnt != '0) begin
          rd_word = {23'h0, 1'b1, errq_ff[st_ff.err_rd]};
        end
      end
      `OCS_ADDR_IRQ_STAT: begin
        rd_word = {29'h0, st_ff.irq_stat};
      end
      `OCS_ADDR_IRQ_EN: begin
        rd_word = {29'h0, st_ff.irq_en};
      end
      `OCS_ADDR_FLAGS: begin
        rd_word = {27'h0, st_ff.holdoff, exec_blocked, st_ff.outq_full, tmr_expired, st_ff.sync != OCS_IDLE};
      end
      default: rd_word = 32'h0;
    endcase
  end

  always_comb begin
    logic [2:0] ev;
    logic cls;
    ev = 3'h0;
    cls = 1'b0;
    nxt_st = st_ff;
    nxt_st.pready = 1'b1;
    // sticky event inputs
    nxt_st.hw1 = st_ff.hw1 | evt_hw1_set;
    nxt_st.hw2 = st_ff.hw2 | evt_hw2_set;
    nxt_st.qdata = st_ff.qdata | evt_qdata_set;
    nxt_st.oper = st_ff.oper | evt_oper_set;
    nxt_st.cal = st_ff.cal | evt_cal_set;
    nxt_st.comm = st_ff.comm | evt_comm_set;
    // hold the read access open while an opc query reply is pending
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == `OCS_ADDR_OUTQ &&
        reply_owed(st_ff)) begin
      nxt_st.pready = 1'b0;
      nxt_st.holdoff = 1'b1;
    end else begin
      nxt_st.holdoff = 1'b0;
    end
    // a held read follows the reply so that it stands on the edge that completes the access
    if (held_rd) begin
      nxt_st.prdata = rd_word;
    end
    // response and read data are fixed in the setup cycle and stand through the access phase, except for a held output queue read
    if (setup_ph) begin
      nxt_st.pready = !(apb_req.paddr == `OCS_ADDR_OUTQ && !apb_req.pwrite && reply_owed(st_ff));
      if (apb_req.pwrite) begin
        nxt_st.pslverr = wr_err;
      end else begin
        nxt_st.pslverr = rd_err;
        nxt_st.prdata = rd_word;
      end
    end
    if (wr_acc) begin
      unique case (apb_req.paddr)
        `OCS_ADDR_CMD: begin
          if (tmr_start) begin
            nxt_st.sync = OCS_SETTLE;
            nxt_st.kind = cmd;
          end
          cls = cls_cmd;
        end
        `OCS_ADDR_ESE: nxt_st.ese = apb_req.pwdata[7:0];
        `OCS_ADDR_SRE: nxt_st.sre = apb_req.pwdata[7:0];
        `OCS_ADDR_IRQ_EN: nxt_st.irq_en = apb_req.pwdata[2:0];
        `OCS_ADDR_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~apb_req.pwdata[2:0];
        default: nxt_st.pslverr = st_ff.pslverr;
      endcase
    end
    if (cls) begin
      // output queue is never touched here; the error queue is emptied
      nxt_st.esr = 8'h0;
      nxt_st.hw1 = evt_hw1_set;
      nxt_st.hw2 = evt_hw2_set;
      nxt_st.qdata = evt_qdata_set;
      nxt_st.oper = evt_oper_set;
      nxt_st.cal = evt_cal_set;
      nxt_st.comm = evt_comm_set;
      nxt_st.err_cnt = '0;
      nxt_st.err_rd = '0;
      nxt_st.err_wr = '0;
    end
    // read side effects touch only what the held read data showed
    if (rd_acc) begin
      unique case (apb_req.paddr)
        `OCS_ADDR_ESR: nxt_st.esr = st_ff.esr & ~st_ff.prdata[7:0];
        `OCS_ADDR_OUTQ: nxt_st.outq_full = 1'b0;
        `OCS_ADDR_ERRQ: begin
          if (st_ff.prdata[8]) begin
            nxt_st.err_rd = PW'(st_ff.err_rd + 1'b1);
            nxt_st.err_cnt = EW'(st_ff.err_cnt - 1'b1);
          end
        end
        default: nxt_st.prdata = st_ff.prdata;
      endcase
    end
    if (errq_we) begin
      nxt_st.err_wr = PW'(nxt_st.err_wr + 1'b1);
      nxt_st.err_cnt = EW'(nxt_st.err_cnt + 1'b1);
    end
    if (sync_done) begin
      nxt_st.sync = OCS_IDLE;
      if (st_ff.kind == `OCS_CMD_OPC) begin
        nxt_st.esr[`OCS_ESR_OPC_BIT] = 1'b1;
        ev[0] = 1'b1;
      end
      if (st_ff.kind == `OCS_CMD_OPCQ) begin
        nxt_st.outq = `OCS_REPLY_CHAR;
        nxt_st.outq_full = 1'b1;
        ev[1] = 1'b1;
      end
      if (st_ff.kind == `OCS_CMD_WAI) begin
        ev[2] = 1'b1;
      end
    end
    // set wins over clear
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{sync: OCS_IDLE, pready: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (errq_we) begin
      errq_ff[st_ff.err_wr] <= err_code;
    end
  end

  assign irq = |(st_ff.irq_stat & st_ff.irq_en);
  assign apb_rsp.prdata = st_ff.prdata;
  assign apb_rsp.pready = st_ff.pready;
  assign apb_rsp.pslverr = st_ff.pslverr;
endmodule

// File: ocs_sync_status_assertions.sv
// checker for the sync and clear-status block
`timescale 1ns/100ps
`include "ocs_consts.svh"
module ocs_sync_status_chk
  import ocs_pkg::*;
#(
  parameter int unsigned NUM_MEAS = 8,
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire ocs_pkg::ocs_apb_req_t apb_req,
  input wire ocs_pkg::ocs_apb_rsp_t apb_rsp,
  input wire logic [NUM_MEAS-1:0] meas_active,
  input wire logic [NUM_MEAS-1:0] meas_done,
  input wire logic meas_report_req,
  input wire logic exec_blocked,
  input wire logic srq
);
  import ocs_pkg::*;
  logic acc, cmdw, waiw, all_done;
  assign all_done = &(meas_done | ~meas_active);
  int unsigned cnt_ff;
  assign acc = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign cmdw = acc & apb_req.pwrite & (apb_req.paddr == `OCS_ADDR_CMD);
  assign waiw = cmdw & (apb_req.pwdata == 32'h3);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= meas_report_req ? cnt_ff + 1 : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sync_starts_settle: assert property (cmdw && apb_req.pwdata inside {32'h1, 32'h2, 32'h3}
    |=> $past(apb_rsp.pslverr) || meas_report_req) else $error("settle not started");
  a_settle_full_time: assert property ($fell(meas_report_req) |-> cnt_ff + 2 >= SETTLE_CYCLES)
    else $error("settle too short");
  a_release_needs_done: assert property ($fell(exec_blocked) |-> $past(all_done))
    else $error("released before done");
  a_block_needs_wai: assert property ($rose(exec_blocked) |-> $past(waiw) || $past(waiw, 2))
    else $error("blocked without wait");
  a_wai_refuses_cmd: assert property (cmdw && exec_blocked |-> apb_rsp.pslverr)
    else $error("command taken while blocked");
  a_holdoff_only_outq: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
    |-> apb_req.paddr == `OCS_ADDR_OUTQ) else $error("holdoff off queue");
  a_reply_after_wait: assert property (acc && !$past(apb_rsp.pready)
    |-> apb_rsp.prdata[7:0] == `OCS_REPLY_CHAR) else $error("held read lacks reply");
  a_srq_in_stb: assert property (acc && !apb_req.pwrite && apb_req.paddr == `OCS_ADDR_STB
    |-> apb_rsp.prdata[6] == $past(srq)) else $error("status byte request bit");
  c_cmd: cover property (cmdw);
  c_release: cover property ($fell(exec_blocked));
  c_srq: cover property ($rose(srq));
endmodule
bind ocs_sync_status ocs_sync_status_chk #(.NUM_MEAS(NUM_MEAS), .SETTLE_CYCLES(SETTLE_CYCLES)) i_ocs_sync_status_chk (
  .clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .meas_active(meas_active),
  .meas_done(meas_done), .meas_report_req(meas_report_req), .exec_blocked(exec_blocked), .srq(srq));

// File: ocs_meas_model.sv
// measurement partner: reports done some cycles after being asked
`timescale 1ns/100ps
module ocs_meas_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic report_req,
  input wire logic slow,
  output logic [1:0] meas_active,
  output logic [1:0] meas_done
);
  int unsigned wait_ff;
  assign meas_active = 2'h1;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_ff <= 0;
    end else begin
      wait_ff <= report_req ? wait_ff + 1 : 0;
    end
  end
  // inactive one never reports done
  assign meas_done = {1'b0, report_req && wait_ff >= (slow ? 40 : 3)};
endmodule

// File: ocs_sync_status_tb.sv
// self-checking bench for the sync and clear-status block
`timescale 1ns/100ps
`include "ocs_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
`define WT(c) for (n = 0; n < 300 && !(c); n++) @(posedge clk);
module ocs_sync_status_tb;
  import ocs_pkg::*;
  logic clk, nrst, mrq, err_push, blk, srq, irq, slow, er;
  ocs_apb_req_t req;
  ocs_apb_rsp_t rsp;
  logic [1:0] act, dn;
  logic [7:0] err_code, evt;
  logic [31:0] rd;
  int num_errors = 0;
  int check_count = 0;
  int n;
  time t;
  ocs_sync_status #(.NUM_MEAS(2), .ERRQ_DEPTH(8), .SETTLE_CYCLES(20)) i_ocs_sync_status (
    .clk(clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .meas_active(act), .meas_done(dn),
    .meas_report_req(mrq), .err_push(err_push), .err_code(err_code), .evt_hw1_set(evt),
    .evt_hw2_set(evt), .evt_qdata_set(evt), .evt_oper_set(evt), .evt_cal_set(evt),
    .evt_comm_set(evt), .exec_blocked(blk), .srq(srq), .irq(irq));
  ocs_meas_model i_ocs_meas_model (.clk(clk), .nrst(nrst), .report_req(mrq), .slow(slow),
    .meas_active(act), .meas_done(dn));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 300);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 300) begin
      num_errors++;
      print_verdict();
    end
    @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    #240000;
    num_errors++;
    print_verdict();
  end
  initial begin
    nrst = 0; slow = 0; err_push = 0; err_code = 8'h00; evt = 8'h00; req = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    apb(1, `OCS_ADDR_ESE, 32'h1);
    apb(1, `OCS_ADDR_SRE, 32'h20);
    apb(1, `OCS_ADDR_IRQ_EN, 32'h7);
    apb(1, `OCS_ADDR_CMD, 32'h1);
    `CHK(srq, 1'b0)
    `WT(irq)
    repeat (2) @(posedge clk);
    `CHK(srq, 1'b1)
    apb(0, `OCS_ADDR_STB, 0);
    `CHK(rd[5], 1'b1)
    apb(0, `OCS_ADDR_IRQ_STAT, 0);
    `CHK(rd[2:0], 3'h1)
    apb(1, `OCS_ADDR_IRQ_CLR, 32'h1);
    `CHK(irq, 1'b0)
    apb(0, `OCS_ADDR_ESR, 0);
    `CHK(rd[0], 1'b1)
    `CHK(srq, 1'b0)
    $display("test opc done");
    apb(1, `OCS_ADDR_IRQ_EN, 32'h0);
    apb(1, `OCS_ADDR_SRE, 32'h10);
    apb(1, `OCS_ADDR_CMD, 32'h2);
    apb(0, `OCS_ADDR_STB, 0);
    `CHK(rd[4], 1'b0)
    `WT(srq)
    `CHK(irq, 1'b0)
    apb(0, `OCS_ADDR_STB, 0);
    `CHK(rd[6:4], 3'h5)
    apb(0, `OCS_ADDR_OUTQ, 0);
    `CHK(rd[7:0], 8'h31)
    `CHK(srq, 1'b0)
    apb(1, `OCS_ADDR_SRE, 32'h0);
    apb(1, `OCS_ADDR_CMD, 32'h2);
    t = $time;
    apb(0, `OCS_ADDR_OUTQ, 0);
    `CHK(rd[7:0], 8'h31)
    `CHK($time - t >= 800, 1'b1)
    $display("test query done");
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      apb(1, `OCS_ADDR_CMD, 32'h3);
      apb(1, `OCS_ADDR_CMD, 32'h1);
      `CHK(er, 1'b1)
      `CHK(blk, 1'b1)
      `WT(!blk)
      `CHK(n + 8 >= (s ? 40 : 20), 1'b1)
    end
    $display("test wait done");
    apb(1, `OCS_ADDR_CMD, 32'h2);
    repeat (2) @(posedge clk);
    `WT(!mrq)
    evt <= 8'hff;
    err_push <= 1'b1;
    err_code <= 8'h5a;
    @(posedge clk);
    evt <= 8'h00;
    err_push <= 1'b0;
    apb(0, `OCS_ADDR_EVT, 0);
    `CHK(rd[31:8], 24'hffffff)
    apb(1, `OCS_ADDR_CMD, 32'h4);
    apb(0, `OCS_ADDR_EVT, 0);
    `CHK(rd, 32'h0)
    apb(0, `OCS_ADDR_ERRQ, 0);
    `CHK(rd[8], 1'b0)
    apb(0, `OCS_ADDR_OUTQ, 0);
    `CHK(rd[7:0], 8'h31)
    apb(0, 12'h034, 0);
    `CHK(er, 1'b1)
    $display("test clear done");
    print_verdict();
  end
endmodule
